// [bench/mlb_peer_model.sv]
// Behavioural remote peer modem seen across the line
`timescale 1ns/1ns
module mlb_peer_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_bit_stb,
   input  wire logic       i_line_txd,
   input  wire logic       i_loop_cmd,
   input  wire logic [1:0] i_mode,
   input  wire logic       i_req,
   input  wire logic       i_valid,
   output logic            o_rxd,
   output logic            o_rx_valid,
   output logic            o_loop_req,
   output logic            o_test_lamp
);
   // ****************************************
   // Pattern source and remote loop
   // ****************************************
   logic [8:0] prbs_q = 9'h1_FF;
   logic       nxt;
   initial o_rxd = 1'h0;
   // Taps at nine and five bits back
   assign nxt = prbs_q[8] ^ prbs_q[4];
   assign o_test_lamp = i_loop_cmd;
   assign o_loop_req = i_req;
   assign o_rx_valid = i_valid;
   // Mode 0 space, 1 pattern, 2 inverted pattern, 3 steady mark
   always @(posedge i_sys_clk) begin
      if (i_bit_stb) begin
         prbs_q <= {prbs_q[7:0], nxt};
         if (i_loop_cmd)
            o_rxd <= i_line_txd;
         else if (i_mode == 2'h0)
            o_rxd <= 1'h0;
         else if (i_mode == 2'h3)
            o_rxd <= 1'h1;
         else
            o_rxd <= nxt ^ i_mode[1];
      end
   end
endmodule // mlb_peer_model

// [bench/tb_top.sv]
// Self-checking bench for the loopback and pattern tester block
`timescale 1ns/1ns
module tb_top;
   // ****************************************
   // Stimulus and observation
   // ****************************************
   logic       clk = 1'h0;
   logic       srst = 1'h1;
   logic [3:0] btn = 4'h0;
   logic       strap = 1'h1;
   logic       alb_en = 1'h0, rlb_en = 1'h0, alb = 1'h0, rlb = 1'h0;
   logic       rts = 1'h0, txd = 1'h0, stb = 1'h0, tgl = 1'h0;
   logic [1:0] scnt = 2'h0, pmode = 2'h0;
   logic       preq = 1'h0, pval = 1'h1, tog = 1'h0;
   logic       rxd, rxv, lreq, ptest, ltxd, lcar, lcmd, drxd, cts, dsr;
   logic       dcd, dtest, pwr_l, rts_l, txd_l, rxd_l, dcd_l, test_l;
   logic       err_l, frdy;
   int         err_count = 0;
   int         comparisons = 0;

   always #2 clk = ~clk;
   // One bit strobe every four clocks
   always @(negedge clk) begin
      scnt <= scnt + 2'h1;
      stb <= (scnt == 2'h3);
      if (scnt == 2'h3)
         tog <= ~tog;
   end

   mlb_top #(.LAMP_CHECK_CYC(20), .BLINK_CYC(8)) i_dut (
      .i_sys_clk(clk), .i_srst(srst),
      .i_analog_loop_button(btn[0]), .i_remote_loop_button(btn[1]),
      .i_local_digital_loop_button(btn[2]),
      .i_pattern_test_button(btn[3]), .i_carrier_strap(strap),
      .i_dte_alb_enable(alb_en), .i_dte_rlb_enable(rlb_en),
      .i_dte_alb_cmd(alb), .i_dte_rlb_cmd(rlb), .i_dte_rts(rts),
      .i_dte_txd(tgl ? tog : txd), .i_bit_stb(stb), .i_line_rxd(rxd),
      .i_line_rx_valid(rxv), .i_peer_loop_req(lreq),
      .o_line_txd(ltxd), .o_line_carrier(lcar), .o_peer_loop_cmd(lcmd),
      .o_dte_rxd(drxd), .o_dte_cts(cts), .o_dte_dsr(dsr),
      .o_dte_dcd(dcd), .o_dte_test(dtest), .o_power_lamp(pwr_l),
      .o_rts_lamp(rts_l), .o_txd_lamp(txd_l), .o_rxd_lamp(rxd_l),
      .o_dcd_lamp(dcd_l), .o_test_lamp(test_l), .o_err_lamp(err_l),
      .o_fifo_ready(frdy));

   mlb_peer_model i_peer (
      .i_sys_clk(clk), .i_bit_stb(stb), .i_line_txd(ltxd),
      .i_loop_cmd(lcmd), .i_mode(pmode), .i_req(preq), .i_valid(pval),
      .o_rxd(rxd), .o_rx_valid(rxv), .o_loop_req(lreq),
      .o_test_lamp(ptest));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic complete_run;
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Lamps settle two edges after the rising edge of a press
   task automatic press(input int b);
      btn[b] = 1'h1;
      cyc(2);
      btn[b] = 1'h0;
      cyc(2);
   endtask
   task automatic flick(input int sel);
      int n;
      logic p, v;
      n = 0;
      p = sel ? rxd_l : txd_l;
      repeat (80) begin
         cyc(1);
         v = sel ? rxd_l : txd_l;
         if (v !== p)
            n++;
         p = v;
      end
      check(32'(n > 4), 32'h1);
   endtask
   // Bounded wait for the error lamp to go dark
   task automatic wait_dark(input int lim);
      int i;
      i = 0;
      while (err_l !== 1'h0 && i < lim) begin
         cyc(1);
         i++;
      end
      check(32'(i < lim), 32'h1);
      if (i >= lim)
         complete_run();
   endtask
   task automatic prbs_chk;
      logic [39:0] b;
      for (int i = 0; i < 40; i++) begin
         cyc(4);
         b[i] = ltxd;
      end
      check(32'(b != 40'h0), 32'h1);
      for (int i = 9; i < 40; i++)
         check(b[i], b[i-9] ^ b[i-5]);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      check(test_l, 1'h0);
      check(err_l, 1'h0);
      check(dsr, 1'h1);
      check(dtest, 1'h0);
      check(pwr_l, 1'h1); // power lamp
      check(frdy, 1'h1); // transmit queue
   endtask
   task automatic t_lamps;
      strap = 1'h0;
      cyc(3);
      check(rts_l, 1'h0);
      check(lcar, 1'h0);
      rts = 1'h1;
      cyc(3);
      check(rts_l, 1'h1);
      check(lcar, 1'h1);
      rts = 1'h0;
      strap = 1'h1;
      pval = 1'h0;
      cyc(60);
      check(lcar, 1'h1);
      check(txd_l, 1'h1);
      check(ltxd, 1'h0);
      check(rxd_l, 1'h1);
      check(dcd_l, 1'h0);
      check(dcd, 1'h0);
      pval = 1'h1;
      cyc(3);
      check(dcd_l, 1'h1);
      check(dcd, 1'h1);
      tgl = 1'h1;
      pmode = 2'h1;
      flick(0);
      flick(1);
      tgl = 1'h0;
   endtask
   task automatic t_analog;
      press(0);
      check(test_l, 1'h1);
      check(dtest, 1'h1);
      check(dcd_l, 1'h1);
      txd = 1'h1;
      cyc(60);
      check(drxd, 1'h1);
      txd = 1'h0;
      pval = 1'h0;
      cyc(60);
      check(drxd, 1'h0);
      check(dcd_l, 1'h1);
      pval = 1'h1;
      press(1);
      check(lcmd, 1'h0);
      press(0);
      check(test_l, 1'h0);
      check(lcmd, 1'h0);
   endtask
   task automatic t_remote;
      press(1);
      check(lcmd, 1'h1);
      check(ptest, 1'h1);
      check(test_l, 1'h1);
      check(dsr, 1'h0);
      press(2);
      press(1);
      check(lcmd, 1'h0);
      check(test_l, 1'h0);
      check(dsr, 1'h1);
      rlb = 1'h1;
      cyc(3);
      check(lcmd, 1'h0);
      rlb = 1'h0;
      rlb_en = 1'h1;
      cyc(2);
      rlb = 1'h1;
      cyc(3);
      check(lcmd, 1'h1);
      rlb = 1'h0;
      cyc(3);
      check(lcmd, 1'h0);
      alb_en = 1'h1;
      alb = 1'h1;
      cyc(3);
      check(test_l, 1'h1);
      check(dcd_l, 1'h1);
      alb = 1'h0;
      cyc(3);
      check(test_l, 1'h0);
   endtask
   task automatic t_digital;
      txd = 1'h1;
      press(2);
      check(test_l, 1'h1);
      check(dsr, 1'h0);
      pmode = 2'h0;
      cyc(60);
      check(ltxd, 1'h0);
      pmode = 2'h3;
      cyc(60);
      check(ltxd, 1'h1);
      press(2);
      check(test_l, 1'h0);
      preq = 1'h1;
      cyc(3);
      check(test_l, 1'h1);
      check(dsr, 1'h0);
      preq = 1'h0;
      txd = 1'h0;
      cyc(3);
      check(test_l, 1'h0);
   endtask
   task automatic t_pattern_test_button;
      press(0);
      press(3);
      check(err_l, 1'h1);
      check(drxd, 1'h0);
      check(cts, 1'h0);
      cyc(10);
      check(err_l, 1'h1);
      wait_dark(400);
      prbs_chk();
      check(err_l, 1'h0);
      press(3);
      press(0);
   endtask
   task automatic t_bert;
      int n;
      strap = 1'h0;
      rts = 1'h1;
      pmode = 2'h1;
      press(3);
      check(err_l, 1'h1);
      wait_dark(400);
      pmode = 2'h2;
      cyc(150);
      n = 0;
      repeat (64) begin
         cyc(1);
         if (err_l === 1'h1)
            n++;
      end
      check(n, 64);
      pmode = 2'h1;
      wait_dark(600);
      press(3);
   endtask

   initial begin
      cyc(12);
      srst = 1'h0;
      cyc(2);
      t_reset();
      t_lamps();
      t_analog();
      t_remote();
      t_digital();
      t_pattern_test_button();
      t_bert();
      complete_run();
   end
endmodule // tb_top

// [logic/mlb_defines.svh]
// Constants for the modem loopback and pattern tester block
`ifndef MLB_DEFINES_SVH
`define MLB_DEFINES_SVH
// Pattern generator polynomial x^9 + x^5 + 1, nine-bit register
`define MLB_PRBS_W        9
`define MLB_PRBS_SEED     9'h1_FF
// Lamp timing at 250 MHz
`define MLB_CLK_MHZ       250
`define MLB_LAMP_CHECK_MS 200
`define MLB_BLINK_MS      100
`define MLB_LAMP_CHECK_CYC (`MLB_LAMP_CHECK_MS * 1000 * `MLB_CLK_MHZ)
`define MLB_BLINK_CYC      (`MLB_BLINK_MS * 1000 * `MLB_CLK_MHZ)
// Errors within this many bits of each other count as continuous
`define MLB_CONT_GAP      16
// Carrier strap encoding
`define MLB_CARRIER_STRAP_ON       1'b1
`define MLB_FIFO_W        1
`define MLB_FIFO_D        16
`endif

// [logic/mlb_fifo.sv]
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module mlb_fifo #(
   parameter int W = 1,
   parameter int D = 16
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_data,
   input  wire logic         i_valid,
   output logic              o_ready,
   output logic [W-1:0]      o_data,
   output logic              o_valid,
   input  wire logic         i_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign o_ready = (cnt_q != (AW+1)'(D));
   assign o_valid = (cnt_q != '0);
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;
   assign o_data  = mem_q[rd_q];

   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= i_data;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_bound: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      cnt_q <= (AW+1)'(D))
      else $error("fifo count above depth");
endmodule // mlb_fifo

// [logic/mlb_pkg.sv]
// Types for the modem loopback and pattern tester block
package mlb_pkg;
   typedef enum logic [1:0] {
      MLB_NORMAL  = 2'b00,
      MLB_ANALOG  = 2'b01,
      MLB_REMOTE  = 2'b10,
      MLB_LOCALDG = 2'b11
   } mlb_loop_t;
endpackage

// [logic/mlb_top.sv]
// Loopback selection, pattern tester and lamp drive of a line modem
// Summary of operation
// [R1] Test lamp lit in any loopback mode, dark otherwise.
// [R2] Transmit lamp on for steady space, follows bits otherwise.
// [R3] Receive lamp on for steady space, follows received bits.
// [R4] Carrier lamp lit only while valid receive signal present.
// [R5] RTS lamp follows the terminal request to send input.
// [R6] Tester makes and checks the 511-bit x9+x5+1 pattern.
// [R7] Error lamp steady for continuous errors, blinks for intermittent.
// [R8] Pattern start lights the error lamp briefly as a lamp check.
// [R9] Pattern test needs carrier on: strap on or RTS high; the code starts and runs the pattern test with carrier off too.
// [R10] Pattern test replaces terminal transmit data with pattern.
// [R11] Tester usable whenever the pattern returns to local receiver.
// [R12] Analog loop feeds own transmitter into own receiver.
// [R13] Terminal pins may also request analog and remote loops.
// [R14] Each loop button toggles its mode on and off.
// [R15] Remote request signals the peer; both show test lamp.
// [R16] Local digital loop sends received line data back out.
// [R17] Analog loop with carrier gives carrier detect and test.
// [R18] Carrier strap picks carrier always on or gated by RTS.
// [R19] Remote digital loop drives data set ready low.
// [R20] Pattern test drives receive data and clear to send low.
// [R21] Lamp check length and blink rate are fixed constants.
// [R22] Only one loop at a time; others ignored while engaged (the peer loop request still acts in analog and remote loop).
`timescale 1ns/1ns
`include "mlb_defines.svh"
module mlb_top
   import mlb_pkg::*;
#(
   parameter int LAMP_CHECK_CYC = `MLB_LAMP_CHECK_CYC,
   parameter int BLINK_CYC      = `MLB_BLINK_CYC
) (
   input  wire logic i_sys_clk,
   input  wire logic i_srst,
   input  wire logic i_analog_loop_button,
   input  wire logic i_remote_loop_button,
   input  wire logic i_local_digital_loop_button,
   input  wire logic i_pattern_test_button,
   input  wire logic i_carrier_strap,
   input  wire logic i_dte_alb_enable,
   input  wire logic i_dte_rlb_enable,
   input  wire logic i_dte_alb_cmd,
   input  wire logic i_dte_rlb_cmd,
   input  wire logic i_dte_rts,
   input  wire logic i_dte_txd,
   input  wire logic i_bit_stb,
   input  wire logic i_line_rxd,
   input  wire logic i_line_rx_valid,
   input  wire logic i_peer_loop_req,
   output logic      o_line_txd,
   output logic      o_line_carrier,
   output logic      o_peer_loop_cmd,
   output logic      o_dte_rxd,
   output logic      o_dte_cts,
   output logic      o_dte_dsr,
   output logic      o_dte_dcd,
   output logic      o_dte_test,
   output logic      o_power_lamp,
   output logic      o_rts_lamp,
   output logic      o_txd_lamp,
   output logic      o_rxd_lamp,
   output logic      o_dcd_lamp,
   output logic      o_test_lamp,
   output logic      o_err_lamp,
   output logic      o_fifo_ready
);
   // ***************************************************************
   // Loop mode selection
   // ***************************************************************
   mlb_loop_t loop_q;
   logic      ana_btn_q, rem_btn_q, dig_btn_q, pat_btn_q;
   logic      alb_cmd_q, rlb_cmd_q;
   logic      ana_req, rem_req, dig_req, pat_press;
   logic      alb_on, rlb_on, alb_off, rlb_off;
   logic      pattern_test_button_q, leave;
   logic      carrier;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         {ana_btn_q, rem_btn_q, dig_btn_q, pat_btn_q} <= 4'h0;
         {alb_cmd_q, rlb_cmd_q}                       <= 2'h0;
      end else begin
         {ana_btn_q, rem_btn_q, dig_btn_q, pat_btn_q} <=
            {i_analog_loop_button, i_remote_loop_button,
             i_local_digital_loop_button, i_pattern_test_button};
         alb_cmd_q <= i_dte_alb_cmd & i_dte_alb_enable;
         rlb_cmd_q <= i_dte_rlb_cmd & i_dte_rlb_enable;
      end
   end

   assign ana_req   = i_analog_loop_button & ~ana_btn_q;
   assign rem_req   = i_remote_loop_button & ~rem_btn_q;
   assign dig_req   = i_local_digital_loop_button & ~dig_btn_q;
   assign pat_press = i_pattern_test_button & ~pat_btn_q;
   // Terminal command pins are levels: rising edge enters, falling leaves
   assign alb_on  = i_dte_alb_cmd & i_dte_alb_enable & ~alb_cmd_q; // R13
   assign alb_off = ~(i_dte_alb_cmd & i_dte_alb_enable) & alb_cmd_q;
   assign rlb_on  = i_dte_rlb_cmd & i_dte_rlb_enable & ~rlb_cmd_q; // R13
   assign rlb_off = ~(i_dte_rlb_cmd & i_dte_rlb_enable) & rlb_cmd_q;
   assign leave   = ((loop_q == MLB_ANALOG) && (ana_req || alb_off))
                    || ((loop_q == MLB_REMOTE) && (rem_req || rlb_off))
                    || ((loop_q == MLB_LOCALDG) && dig_req);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         loop_q <= MLB_NORMAL;
      end else begin
         case (loop_q)
            MLB_NORMAL: begin
               // Fixed priority picks one when requests coincide
               if (ana_req || alb_on) begin // R22
                  loop_q <= MLB_ANALOG;
               end else if (rem_req || rlb_on) begin
                  loop_q <= MLB_REMOTE;
               end else if (dig_req) begin
                  loop_q <= MLB_LOCALDG;
               end
            end
            MLB_ANALOG, MLB_REMOTE, MLB_LOCALDG: begin
               if (leave) begin // R14
                  loop_q <= MLB_NORMAL;
               end
            end
            default: loop_q <= MLB_NORMAL;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         pattern_test_button_q <= 1'b0;
      end else if (pat_press) begin
         pattern_test_button_q <= ~pattern_test_button_q;
      end
   end

   // ***************************************************************
   // Transmit path through the FIFO
   // ***************************************************************
   logic [`MLB_PRBS_W-1:0] gen_q;
   logic                   gen_bit;
   logic                   tx_src;
   logic                   fifo_bit;
   logic                   fifo_valid;
   logic                   tx_q;
   logic                   peer_loop;

   assign gen_bit   = gen_q[8] ^ gen_q[4]; // R6
   assign peer_loop = i_peer_loop_req || (loop_q == MLB_LOCALDG);
   always_comb begin
      if (peer_loop) begin
         tx_src = i_line_rxd; // R16
      end else if (pattern_test_button_q) begin
         tx_src = gen_bit; // R10
      end else begin
         tx_src = i_dte_txd;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         gen_q <= `MLB_PRBS_SEED;
      end else if (i_bit_stb && o_fifo_ready && pattern_test_button_q) begin
         gen_q <= {gen_q[7:0], gen_bit}; // R6
      end
   end

   // Filled and drained one bit per strobe, so it holds one bit and never stalls
   mlb_fifo #(.W(`MLB_FIFO_W), .D(`MLB_FIFO_D)) u_txq (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_data    (tx_src),
      .i_valid   (i_bit_stb),
      .o_ready   (o_fifo_ready),
      .o_data    (fifo_bit),
      .o_valid   (fifo_valid),
      .i_ready   (i_bit_stb)
   );

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tx_q <= 1'b0;
      end else if (i_bit_stb && fifo_valid) begin
         tx_q <= fifo_bit;
      end
   end

   assign carrier = (i_carrier_strap == `MLB_CARRIER_STRAP_ON) || i_dte_rts; // R18 R9

   // ***************************************************************
   // Receive path and pattern checker
   // ***************************************************************
   logic                   rx_bit;
   logic                   rx_valid;
   logic [`MLB_PRBS_W-1:0] chk_q;
   logic                   chk_err;
   logic                   err_q;

   // Analog loop echoes own transmit stream, valid only with carrier
   assign rx_bit   = (loop_q == MLB_ANALOG) ? tx_q : i_line_rxd; // R12
   assign rx_valid = (loop_q == MLB_ANALOG) ? carrier : i_line_rx_valid; // R17
   // Self-synchronising check works for any loop returning the pattern
   assign chk_err  = rx_bit ^ chk_q[8] ^ chk_q[4]; // R11

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         chk_q <= `MLB_PRBS_SEED;
         err_q <= 1'b0;
      end else if (i_bit_stb) begin
         chk_q <= {chk_q[7:0], rx_bit}; // R6
         err_q <= pattern_test_button_q & rx_valid & chk_err;
      end else begin
         err_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Error lamp: lamp check, continuous and intermittent errors
   // ***************************************************************
   logic [31:0] chk_cnt_q;
   logic [31:0] blink_cnt_q;
   logic [4:0]  gap_q;
   logic        blink_q;
   logic        hold_q;
   logic        cont;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         chk_cnt_q <= '0;
      end else if (pat_press && !pattern_test_button_q) begin
         chk_cnt_q <= 32'(LAMP_CHECK_CYC); // R8 R21
      end else if (chk_cnt_q != '0) begin
         chk_cnt_q <= chk_cnt_q - 32'h0000_0001;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst || !pattern_test_button_q) begin
         gap_q <= 5'h1F;
      end else if (err_q) begin
         gap_q <= '0;
      end else if (i_bit_stb && gap_q != 5'h1F) begin
         gap_q <= gap_q + 5'h01;
      end
   end
   assign cont = (gap_q < 5'(`MLB_CONT_GAP));

   // An error holds the blink going for one blink period at least
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || !pattern_test_button_q) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b0;
         hold_q      <= 1'b0;
      end else if (blink_cnt_q == '0) begin
         blink_cnt_q <= 32'(BLINK_CYC - 1); // R21
         blink_q     <= ~blink_q & (hold_q | err_q);
         hold_q      <= err_q;
      end else begin
         blink_cnt_q <= blink_cnt_q - 32'h0000_0001;
         if (err_q) begin
            hold_q <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // Lamps and terminal outputs
   // ***************************************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         {o_power_lamp, o_rts_lamp, o_txd_lamp, o_rxd_lamp} <= 4'h0;
         {o_dcd_lamp, o_test_lamp, o_err_lamp}              <= 3'h0;
         {o_line_carrier, o_peer_loop_cmd}                  <= 2'h0;
         {o_dte_cts, o_dte_dsr, o_dte_dcd, o_dte_test}      <= 4'h0;
         o_line_txd                                         <= 1'b1;
         o_dte_rxd                                          <= 1'b1;
      end else begin
         o_power_lamp    <= 1'b1;
         o_rts_lamp      <= i_dte_rts; // R5
         // Space is logic 0, so an inverted bit lights on steady space
         o_txd_lamp      <= ~tx_q; // R2
         o_rxd_lamp      <= ~rx_bit; // R3
         o_dcd_lamp      <= rx_valid; // R4
         o_test_lamp     <= (loop_q != MLB_NORMAL) || i_peer_loop_req; // R1 R15
         o_err_lamp      <= (chk_cnt_q != '0)
                            || (pattern_test_button_q && (cont || blink_q)); // R7 R8
         o_line_txd      <= tx_q;
         o_line_carrier  <= carrier || peer_loop;
         o_peer_loop_cmd <= (loop_q == MLB_REMOTE); // R15
         o_dte_rxd       <= pattern_test_button_q ? 1'b0 : rx_bit; // R20
         o_dte_cts       <= pattern_test_button_q ? 1'b0 : carrier; // R20
         o_dte_dsr       <= (loop_q != MLB_REMOTE) && !peer_loop; // R19
         o_dte_dcd       <= pattern_test_button_q ? 1'b0 : rx_valid;
         o_dte_test      <= (loop_q != MLB_NORMAL) || i_peer_loop_req; // R1
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_test_lamp: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      ##1 o_test_lamp == ($past(loop_q) != MLB_NORMAL
                          || $past(i_peer_loop_req))) // R1
      else $error("test lamp wrong for loop mode");
   a_rts_lamp: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      ##1 o_rts_lamp == $past(i_dte_rts)) // R5
      else $error("rts lamp does not follow rts");
   a_one_loop: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (loop_q == MLB_ANALOG) && !ana_req && !alb_off |=>
      loop_q == MLB_ANALOG) // R22
      else $error("analog loop left without request");
   a_loop_toggle: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (loop_q == MLB_LOCALDG) && dig_req |=> loop_q == MLB_NORMAL) // R14
      else $error("digital loop did not end on press");
   a_dsr_remote: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      loop_q == MLB_REMOTE |=> !o_dte_dsr && o_peer_loop_cmd) // R19
      else $error("dsr high or peer not told in remote loop");
   a_pattern_test_button_mute: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      pattern_test_button_q |=> !o_dte_rxd && !o_dte_cts) // R20
      else $error("terminal not muted in pattern test");
   a_lamp_check: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      pat_press && !pattern_test_button_q |=> ##2 o_err_lamp [*2]) // R8
      else $error("no lamp check on pattern start");
   a_carrier_on: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      i_carrier_strap |=> o_line_carrier) // R18
      else $error("carrier off with strap on");
   a_ana_dcd: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      loop_q == MLB_ANALOG && carrier |=> o_dcd_lamp && o_test_lamp) // R17
      else $error("analog loop without carrier detect");
   c_analog: cover property (@(posedge i_sys_clk) loop_q == MLB_ANALOG);
   c_remote: cover property (@(posedge i_sys_clk) loop_q == MLB_REMOTE);
   c_pattern_test_button_err: cover property (@(posedge i_sys_clk) pattern_test_button_q && err_q);
   c_fifo_full: cover property (@(posedge i_sys_clk) !o_fifo_ready);
endmodule // mlb_top
